/* File: core/secondary_config_header_regs.sv */
// Secondary configuration header register bank with AXI4-Lite access and window decode.
`timescale 1ns/1ps
`default_nettype none
`include "sec_cfg_consts.svh"
module secondary_config_header_regs
    import sec_cfg_pkg::*;
(
    input wire logic clk_sys, // System clock, 10 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic reverse_mode, // Bridge runs in reverse direction.
    input wire logic pcix_mode, // Secondary bus runs PCI-X.
    input wire logic setup_load, // Loader writes the setup register.
    input wire word_type setup_load_data, // Value from the loader.
    input wire logic lookup_valid, // Address to decode is present.
    input wire logic lookup_is_io, // Address is an I/O space address.
    input wire word_type lookup_addr, // Address to decode.
    output logic csr_hit, // Hit in the own register page.
    output logic fwd_hit, // Hit forwarded upstream.
    output logic io_hit, // Hit in the I/O window.
    output word_type fwd_addr, // Translated upstream address.
    output logic [11:0] csr_offset, // Offset inside the register page.
    output logic [7:0] latency_timer, // Current secondary latency timer.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire addr_type s_axi_awaddr, // Write address.
    input wire logic [2:0] s_axi_awprot, // Write protection, unused.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    input wire word_type s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    output resp_type s_axi_bresp, // Write response.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    input wire addr_type s_axi_araddr, // Read address.
    input wire logic [2:0] s_axi_arprot, // Read protection, unused.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    output word_type s_axi_rdata, // Read data.
    output resp_type s_axi_rresp // Read response.
);
    logic wr_en;
    addr_type wr_addr;
    word_type wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    addr_type rd_addr;
    word_type rd_word;
    logic rd_ok;
    word_type lane_mask;
    logic [7:0] lat_reg;
    page_type mem_base_reg;
    logic [23:0] io_base_reg;
    page_type xlat_reg;
    word_type setup_reg;
    page_type size_mask;
    word_type lat_hdr_word;
    word_type mem_bar_word;
    word_type io_bar_word;

    // ==========================================================
    // Bus front end
    axi_lite_front u_front (
        .clk_sys(clk_sys),
        .srst(srst),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_word(rd_word),
        .rd_ok(rd_ok)
    );

    assign lane_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign size_mask = setup_reg[31:`CSR_OFF_W];
    assign latency_timer = lat_reg;

    // ==========================================================
    // Address map
    always_comb begin
        wr_ok = 1'b0;
        unique case (wr_addr)
            `OFF_LAT_HDR, `OFF_MEM_BAR, `OFF_IO_BAR, `OFF_XLAT, `OFF_SETUP: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // ==========================================================
    // Secondary latency timer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lat_reg <= pcix_mode && !reverse_mode ? `LAT_RST_PCIX : `LAT_RST_PCI;
        end else if (reverse_mode) begin
            lat_reg <= `LAT_RST_PCI;
        end else if (wr_en && wr_addr == `OFF_LAT_HDR && wr_strb[1]) begin
            lat_reg <= wr_data[15:8];
        end
    end

    // ==========================================================
    // Memory window base, one bit at a time under the setup mask
    generate
        for (genvar i = 0; i < 20; i++) begin : g_base_bit
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    mem_base_reg[i] <= 1'b0;
                end else if (wr_en && wr_addr == `OFF_MEM_BAR && size_mask[i] &&
                    lane_mask[i+`CSR_OFF_W]) begin
                    mem_base_reg[i] <= wr_data[i+`CSR_OFF_W];
                end
            end
        end
    endgenerate

    // ==========================================================
    // I/O window base
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            io_base_reg <= `IO_BASE_RST;
        end else if (wr_en && wr_addr == `OFF_IO_BAR) begin
            io_base_reg <= (io_base_reg & ~lane_mask[31:8]) | (wr_data[31:8] & lane_mask[31:8]);
        end
    end

    // ==========================================================
    // Translated base and setup
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            xlat_reg <= `XLAT_RST;
        end else if (wr_en && wr_addr == `OFF_XLAT) begin
            xlat_reg <= (xlat_reg & ~lane_mask[31:12]) | (wr_data[31:12] & lane_mask[31:12]);
        end
    end

    // The loader wins over a bus write in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            setup_reg <= `SETUP_RST;
        end else if (setup_load) begin
            setup_reg <= setup_load_data;
        end else if (wr_en && wr_addr == `OFF_SETUP) begin
            setup_reg <= (setup_reg & ~lane_mask) | (wr_data & lane_mask);
        end
    end

    // ==========================================================
    // Read path, free of side effects
    assign lat_hdr_word = {8'h00, 1'b0, `HDR_CFG_RST, lat_reg, 8'h00};
    assign mem_bar_word = {mem_base_reg, `MEM_LOW_RO};
    assign io_bar_word = {io_base_reg, `IO_LOW_RO};

    always_comb begin
        rd_word = `RD_UNMAPPED;
        rd_ok = 1'b1;
        unique case (rd_addr)
            `OFF_LAT_HDR: rd_word = lat_hdr_word;
            `OFF_MEM_BAR: rd_word = mem_bar_word;
            `OFF_IO_BAR: rd_word = io_bar_word;
            `OFF_XLAT: rd_word = {xlat_reg, 12'h000};
            `OFF_SETUP: rd_word = setup_reg;
            default: rd_ok = 1'b0;
        endcase
    end

    // ==========================================================
    // Window decode
    window_decoder u_decode (
        .clk_sys(clk_sys),
        .srst(srst),
        .lookup_valid(lookup_valid),
        .lookup_is_io(lookup_is_io),
        .lookup_addr(lookup_addr),
        .mem_base(mem_base_reg),
        .size_mask(size_mask),
        .xlat_base(xlat_reg),
        .io_base(io_base_reg),
        .csr_hit(csr_hit),
        .fwd_hit(fwd_hit),
        .io_hit(io_hit),
        .fwd_addr(fwd_addr),
        .csr_offset(csr_offset)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence s_lat_write;
        wr_en && wr_addr == `OFF_LAT_HDR && wr_strb[1] && !reverse_mode;
    endsequence

    sequence s_bar_write;
        wr_en && wr_addr == `OFF_MEM_BAR;
    endsequence

    sequence s_io_write;
        wr_en && wr_addr == `OFF_IO_BAR;
    endsequence

    sequence s_setup_write;
        wr_en && wr_addr == `OFF_SETUP && !setup_load;
    endsequence

    a_lat_reverse_zero: assert property (
        reverse_mode |=> lat_reg == `LAT_RST_PCI)
        else $error("latency timer not zero in reverse direction");
    a_lat_reset_value: assert property (
        $past(srst) && !$past(reverse_mode) |->
        lat_reg == ($past(pcix_mode) ? `LAT_RST_PCIX : `LAT_RST_PCI))
        else $error("latency timer reset value wrong for the bus mode");
    a_lat_write_takes: assert property (
        s_lat_write ##1 !reverse_mode |-> lat_reg == $past(wr_data[15:8]))
        else $error("latency timer write not taken in forward direction");
    a_hdr_fields_zero: assert property (
        rd_addr == `OFF_LAT_HDR |-> rd_word[31:16] == 16'h0000 && rd_ok)
        else $error("header type or reserved bits not zero");
    a_single_function: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_LAT_HDR |=>
        s_axi_rvalid && !s_axi_rdata[23])
        else $error("single function bit not zero");
    a_bar_low_zero: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_MEM_BAR |=>
        s_axi_rdata[11:0] == 12'h000 && s_axi_rresp == `RESP_OKAY)
        else $error("memory window low bits not zero");
    a_base_masked: assert property (
        ((mem_base_reg ^ $past(mem_base_reg)) & ~$past(size_mask)) == 20'h00000)
        else $error("memory base bit changed without its setup bit");
    a_base_write: assert property (
        s_bar_write ##1 1'b1 |-> ((mem_base_reg ^ $past(wr_data[31:12])) &
        $past(size_mask) & $past(lane_mask[31:12])) == 20'h00000)
        else $error("enabled memory base bit not written");
    a_setup_load: assert property (
        setup_load |=> setup_reg == $past(setup_load_data))
        else $error("setup register not loaded by the loader");
    a_io_flags: assert property (
        rd_addr == `OFF_IO_BAR |-> rd_word[7:0] == 8'h01)
        else $error("I/O window low byte not 01h");
    a_ro_ignore: assert property (
        wr_en && wr_addr == `OFF_LAT_HDR && reverse_mode |=> $stable(mem_base_reg) &&
        lat_reg == `LAT_RST_PCI)
        else $error("write to read-only field changed state");
    a_write_answer: assert property (
        wr_en |=> s_axi_bvalid && s_axi_bresp == ($past(wr_ok) ? `RESP_OKAY : `RESP_SLVERR))
        else $error("write answer missing or wrong");
    a_io_base_write: assert property (
        s_io_write |=> ((io_base_reg ^ $past(wr_data[31:8])) &
        $past(lane_mask[31:8])) == 24'h000000)
        else $error("enabled I/O base byte not written");
    a_setup_write: assert property (
        s_setup_write |=> ((setup_reg ^ $past(wr_data)) & $past(lane_mask)) == 32'h00000000)
        else $error("setup register write not taken");
    a_xlat_low_zero: assert property (
        rd_addr == `OFF_XLAT |-> rd_word[11:0] == 12'h000 && rd_ok)
        else $error("translated base low bits not zero");
    a_lat_hold: assert property (
        !reverse_mode && !(wr_en && wr_addr == `OFF_LAT_HDR && wr_strb[1]) |=>
        $stable(lat_reg))
        else $error("latency timer changed without a write");
    a_unmapped_read: assert property (
        s_axi_arvalid && s_axi_arready && !rd_ok |=>
        s_axi_rresp == `RESP_SLVERR && s_axi_rdata == `RD_UNMAPPED)
        else $error("unmapped read not refused");
    a_read_no_effect: assert property (
        s_axi_arvalid && s_axi_arready && !wr_en && !setup_load |=>
        $stable(setup_reg) && $stable(xlat_reg) && $stable(io_base_reg) &&
        $stable(mem_base_reg))
        else $error("read changed register state");
    a_unmapped_write: assert property (
        wr_en && !wr_ok && !setup_load |=>
        $stable(setup_reg) && $stable(xlat_reg) && $stable(io_base_reg) &&
        $stable(mem_base_reg))
        else $error("unmapped write changed register state");
endmodule
`default_nettype wire

/* File: core/sec_cfg_consts.svh */
// Constants for the secondary configuration header register bank.
`ifndef SEC_CFG_CONSTS_SVH
`define SEC_CFG_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define OFF_LAT_HDR 8'h4c
`define OFF_MEM_BAR 8'h50
`define OFF_IO_BAR 8'h54
`define OFF_XLAT 8'he0
`define OFF_SETUP 8'he4

// ==========================================================
// Reset values and field layout
`define LAT_RST_PCI 8'h00
`define LAT_RST_PCIX 8'h40
`define HDR_CFG_RST 7'h00
`define MEM_BASE_RST 20'h00000
`define IO_BASE_RST 24'h000000
`define XLAT_RST 20'h00000
`define SETUP_RST 32'h00000000
`define MEM_LOW_RO 12'h000
`define IO_LOW_RO 8'h01
`define CSR_OFF_W 12

// ==========================================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RD_UNMAPPED 32'h00000000

`endif

/* File: core/sec_cfg_pkg.sv */
// Types shared by the secondary configuration header register bank.
package sec_cfg_pkg;
    typedef logic [31:0] word_type;
    typedef logic [7:0] addr_type;
    typedef logic [19:0] page_type;
    typedef logic [1:0] resp_type;
endpackage

/* File: core/axi_lite_front.sv */
// AXI4-Lite slave front end turning channel handshakes into register strobes.
`timescale 1ns/1ps
`default_nettype none
`include "sec_cfg_consts.svh"
module axi_lite_front
    import sec_cfg_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic srst, // Synchronous reset.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire addr_type s_axi_awaddr, // Write address.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    input wire word_type s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    output resp_type s_axi_bresp, // Write response.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    input wire addr_type s_axi_araddr, // Read address.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    output word_type s_axi_rdata, // Read data.
    output resp_type s_axi_rresp, // Read response.
    output logic wr_en, // Register write strobe.
    output addr_type wr_addr, // Register write address.
    output word_type wr_data, // Register write data.
    output logic [3:0] wr_strb, // Register write byte lanes.
    input wire logic wr_ok, // Write address is mapped.
    output addr_type rd_addr, // Register read address.
    input wire word_type rd_word, // Register read value.
    input wire logic rd_ok // Read address is mapped.
);
    logic aw_held_reg;
    logic w_held_reg;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_en = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign rd_addr = s_axi_araddr;

    // ==========================================================
    // Write channel capture
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            aw_held_reg <= 1'b0;
            wr_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end else if (wr_en) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            w_held_reg <= 1'b0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end else if (wr_en) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Read channel
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ok ? rd_word : `RD_UNMAPPED;
            s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: core/window_decoder.sv */
// Decoder of the memory and I/O windows with direct upstream address translation.
`timescale 1ns/1ps
`default_nettype none
`include "sec_cfg_consts.svh"
module window_decoder
    import sec_cfg_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic srst, // Synchronous reset.
    input wire logic lookup_valid, // Address to decode is present.
    input wire logic lookup_is_io, // Address is an I/O space address.
    input wire word_type lookup_addr, // Address to decode.
    input wire page_type mem_base, // Memory window base page.
    input wire page_type size_mask, // Writable base bits, which size the window.
    input wire page_type xlat_base, // Translated base page.
    input wire logic [23:0] io_base, // I/O window base.
    output logic csr_hit, // Hit in the own register page.
    output logic fwd_hit, // Hit above the register page, forwarded.
    output logic io_hit, // Hit in the I/O window.
    output word_type fwd_addr, // Translated upstream address.
    output logic [11:0] csr_offset // Offset inside the register page.
);
    page_type page;
    logic mem_hit;
    logic above_csr;

    assign page = lookup_addr[31:`CSR_OFF_W];
    // An all-zero mask leaves the window closed; a full mask is 4KB, bit 31 alone 2GB.
    assign mem_hit = !lookup_is_io && (size_mask != 20'h00000) &&
        (((page ^ mem_base) & size_mask) == 20'h00000);
    assign above_csr = (page & ~size_mask) != 20'h00000;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            csr_hit <= 1'b0;
            fwd_hit <= 1'b0;
            io_hit <= 1'b0;
            fwd_addr <= 32'h00000000;
            csr_offset <= 12'h000;
        end else begin
            csr_hit <= lookup_valid && mem_hit && !above_csr;
            fwd_hit <= lookup_valid && mem_hit && above_csr;
            io_hit <= lookup_valid && lookup_is_io && lookup_addr[31:8] == io_base;
            fwd_addr <= {(xlat_base & size_mask) | (page & ~size_mask),
                lookup_addr[`CSR_OFF_W-1:0]};
            csr_offset <= lookup_addr[`CSR_OFF_W-1:0];
        end
    end

    a_fwd_translate: assert property (@(posedge clk_sys) disable iff (srst)
        lookup_valid && mem_hit && above_csr |=> fwd_hit &&
        fwd_addr[31:12] == (($past(xlat_base) & $past(size_mask)) |
        ($past(page) & ~$past(size_mask))))
        else $error("forwarded address not translated from the translated base");
    a_csr_page: assert property (@(posedge clk_sys) disable iff (srst)
        lookup_valid && mem_hit && !above_csr |=> csr_hit && !fwd_hit)
        else $error("lowest 4KB of the window not decoded as registers");
endmodule
`default_nettype wire

/* File: dv/secondary_config_header_regs_bench.sv */
// Self-checking bench of the secondary configuration header register bank.
`timescale 1ns/1ps
`default_nettype none
`include "sec_cfg_consts.svh"
module secondary_config_header_regs_bench
    import sec_cfg_pkg::*;
;
    // ==========================================================
    // Stimulus tables
    typedef struct packed {addr_type a; word_type d; word_type q;} row_type;
    typedef struct packed {logic io; word_type a; logic [2:0] h; word_type f;} look_type;
    row_type rows [6] = '{
        '{8'h50, 32'hffffffff, 32'h00000000},
        '{8'he4, 32'hffffe000, 32'hffffe000},
        '{8'h50, 32'h1234567f, 32'h12344000},
        '{8'he0, 32'habcdefff, 32'habcde000},
        '{8'h54, 32'h5a5a5afe, 32'h5a5a5a01},
        '{8'h4c, 32'hffffffff, 32'h0000ff00}};
    look_type looks [4] = '{
        '{1'b0, 32'h12344abc, 3'b100, 32'h0},
        '{1'b0, 32'h12345010, 3'b010, 32'habcdf010},
        '{1'b1, 32'h5a5a5a33, 3'b001, 32'h0},
        '{1'b0, 32'h12346000, 3'b000, 32'h0}};
    logic clk_sys, srst, reverse_mode, pcix_mode, setup_load, lookup_valid, lookup_is_io;
    logic csr_hit, fwd_hit, io_hit, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    word_type setup_load_data, lookup_addr, fwd_addr, s_axi_wdata, s_axi_rdata;
    addr_type s_axi_awaddr, s_axi_araddr;
    resp_type s_axi_bresp, s_axi_rresp;
    logic [11:0] csr_offset;
    logic [7:0] latency_timer;
    logic [3:0] s_axi_wstrb;
    int failures = 0;
    int comparisons = 0;
    secondary_config_header_regs i_dut (.clk_sys(clk_sys), .srst(srst),
        .reverse_mode(reverse_mode), .pcix_mode(pcix_mode), .setup_load(setup_load),
        .setup_load_data(setup_load_data), .lookup_valid(lookup_valid),
        .lookup_is_io(lookup_is_io), .lookup_addr(lookup_addr), .csr_hit(csr_hit),
        .fwd_hit(fwd_hit), .io_hit(io_hit), .fwd_addr(fwd_addr), .csr_offset(csr_offset),
        .latency_timer(latency_timer), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // ==========================================================
    // Tasks
    task automatic give_verdict();
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input word_type got, input word_type exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wc(input addr_type a, input word_type d, input resp_type er);
        logic aw_t, w_t, b_t;
        resp_type r;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b_t = 1'b0;
        for (int n = 0; n < 20 && !b_t; n++) begin
            @(negedge clk_sys);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge clk_sys);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (!b_t) failures++;
        if (!b_t) give_verdict();
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rc(input addr_type a, input word_type q, input resp_type er);
        logic ar_t, r_t;
        word_type d;
        resp_type r;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r_t = 1'b0;
        for (int n = 0; n < 20 && !r_t; n++) begin
            @(negedge clk_sys);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid === 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_sys);
            if (ar_t) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (!r_t) failures++;
        if (!r_t) give_verdict();
        chk(d, q);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic look(input logic io, input word_type a);
        @(posedge clk_sys);
        lookup_valid <= 1'b1;
        lookup_is_io <= io;
        lookup_addr <= a;
        @(posedge clk_sys);
        lookup_valid <= 1'b0;
        @(negedge clk_sys);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {srst, reverse_mode, pcix_mode, setup_load, lookup_valid, lookup_is_io} = 6'b100000;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {setup_load_data, lookup_addr, s_axi_wdata, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        rc(`OFF_LAT_HDR, 32'h0, `RESP_OKAY);
        rc(`OFF_MEM_BAR, 32'h0, `RESP_OKAY);
        rc(`OFF_IO_BAR, 32'h1, `RESP_OKAY);
        foreach (rows[i]) begin
            wc(rows[i].a, rows[i].d, `RESP_OKAY);
            rc(rows[i].a, rows[i].q, `RESP_OKAY);
        end
        chk({24'h0, latency_timer}, 32'hff);
        foreach (looks[i]) begin
            look(looks[i].io, looks[i].a);
            chk({29'h0, csr_hit, fwd_hit, io_hit}, {29'h0, looks[i].h});
            if (looks[i].h[2]) chk({20'h0, csr_offset}, {20'h0, looks[i].a[11:0]});
            if (looks[i].h[1]) chk(fwd_addr, looks[i].f);
        end
        wc(8'h10, 32'hffffffff, `RESP_SLVERR);
        rc(8'h10, `RD_UNMAPPED, `RESP_SLVERR);
        reverse_mode <= 1'b1;
        rc(`OFF_LAT_HDR, 32'h0, `RESP_OKAY);
        wc(`OFF_LAT_HDR, 32'h0000ff00, `RESP_OKAY);
        rc(`OFF_LAT_HDR, 32'h0, `RESP_OKAY);
        reverse_mode <= 1'b0;
        pcix_mode <= 1'b1;
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        rc(`OFF_LAT_HDR, 32'h00004000, `RESP_OKAY);
        s_axi_wstrb <= 4'hd;
        wc(`OFF_LAT_HDR, 32'hffffffff, `RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rc(`OFF_LAT_HDR, 32'h00004000, `RESP_OKAY);
        rc(`OFF_SETUP, 32'h0, `RESP_OKAY);
        setup_load_data <= 32'h80000000;
        setup_load <= 1'b1;
        @(posedge clk_sys);
        setup_load <= 1'b0;
        rc(`OFF_SETUP, 32'h80000000, `RESP_OKAY);
        wc(`OFF_MEM_BAR, 32'hffffffff, `RESP_OKAY);
        rc(`OFF_MEM_BAR, 32'h80000000, `RESP_OKAY);
        look(1'b0, 32'h80000fff);
        chk({30'h0, csr_hit, fwd_hit}, 32'h2);
        look(1'b0, 32'hfffff123);
        chk({30'h0, csr_hit, fwd_hit}, 32'h1);
        look(1'b0, 32'h7fffffff);
        chk({30'h0, csr_hit, fwd_hit}, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
